// ### seb_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module seb_ctrl (
    // system
    input wire logic clk,
    // bus
    input wire logic sda,
    output var logic scl = 1'b1,
    output var logic sda_drv = 1'b1
);
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // 160 ns bus clock; data moves only while low
    task automatic bc(input logic d, output logic q);
        scl <= 1'b0;
        tk(1);
        sda_drv <= d;
        tk(3);
        scl <= 1'b1;
        tk(3);
        q = sda;
        tk(1);
    endtask
    task automatic start();
        scl <= 1'b0;
        tk(1);
        // raise data while low, never together with the clock
        sda_drv <= 1'b1;
        tk(3);
        scl <= 1'b1;
        tk(4);
        sda_drv <= 1'b0;
        tk(4);
    endtask
    task automatic stop();
        scl <= 1'b0;
        tk(1);
        sda_drv <= 1'b0;
        tk(3);
        scl <= 1'b1;
        tk(4);
        sda_drv <= 1'b1;
        tk(4);
    endtask
    // msb first, ninth clock left to the device
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) bc(b[i], ack);
        bc(1'b1, ack);
    endtask
    task automatic rbyte(output logic [7:0] b, input logic nack);
        logic q;
        for (int i = 7; i >= 0; i--) bc(1'b1, b[i]);
        bc(nack, q);
    endtask
    task automatic recover();
        logic q;
        repeat (9) bc(1'b1, q);
    endtask
endmodule
`default_nettype wire

// ### seb_defines.vh
`ifndef SEB_DEFINES_VH
`define SEB_DEFINES_VH
// address word prefix, most significant first
`define SEB_PREFIX 5'h14
`define SEB_PREFIX_HI 7
`define SEB_PREFIX_LO 3
`define SEB_SEL_BIT 2
`define SEB_PAGE_BIT 1
`define SEB_RW_BIT 0
// write cycle time in ms and the derived count
`define SEB_CLK_HZ 50000000
`define SEB_WR_TIME_MS 10
`define SEB_WR_CYCLES ((`SEB_CLK_HZ / 1000) * `SEB_WR_TIME_MS)
`endif

// ### seb_props.sv
`timescale 1ns/100ps
`default_nettype none
module seb_props #(
    parameter WR_CYCLES = 500000
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // watched ports
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic write_protect,
    input wire logic standby,
    input wire logic busy,
    input wire logic wr_data_valid,
    input wire logic rd_next,
    input wire logic write_start
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // counter, a repetition this long would stall the tools
    logic [19:0] bcnt;
    always @(posedge clk) bcnt <= (rst || !busy) ? 20'h0 : bcnt + 20'h1;
    property p_rst; $fell(rst) |-> standby && !busy && !sda_oe; endproperty
    a_rst: assert property (p_rst) else $error("not idle after reset");
    property p_blen; busy |-> bcnt <= WR_CYCLES; endproperty
    a_blen: assert property (p_blen) else $error("write cycle too long");
    property p_wsb; write_start |-> ##[0:1] busy; endproperty
    a_wsb: assert property (p_wsb) else $error("no busy after write start");
    property p_quiet; busy |-> !sda_oe && !standby; endproperty
    a_quiet: assert property (p_quiet) else $error("active while busy");
    property p_bend; $fell(busy) |-> ##[0:1] standby; endproperty
    a_bend: assert property (p_bend) else $error("no standby after write");
    // protect pin reaches the logic through two flops and one register
    property p_wp; $past(write_protect, 3) |-> !wr_data_valid && !write_start; endproperty
    a_wp: assert property (p_wp) else $error("write while protected");
    property p_ack; $rose(sda_oe) |-> sda_oe[*6]; endproperty
    a_ack: assert property (p_ack) else $error("low drive too short");
    property p_pls; wr_data_valid || rd_next |=> !wr_data_valid && !rd_next; endproperty
    a_pls: assert property (p_pls) else $error("pulse too long");
    property p_od; sda_oe |-> !sda_out; endproperty
    a_od: assert property (p_od) else $error("data pin driven high");
    cover property (write_start);
    cover property ($fell(busy));
    cover property (rd_next);
endmodule
`default_nettype wire

// ### seb_slave.v
// Functional notes
// - data changes only while clock low
// - falling data, clock high starts transfer
// - rising data, clock high ends transfer
// - stop after read enters standby
// - acknowledge each byte on ninth clock
// - standby at reset and after writes
// - address word follows every start
// - respond only when select matches pin
// - seventh bit is word address top
// - eighth bit selects read or write
// - matching address is acknowledged low
// - mismatch leaves bus until next start
// - protect pin blocks all writes
// - internal write ends within 10 ms
// - ignore inputs while write runs
// - word address is seventeen bits
`timescale 1ns/100ps
`default_nettype none
`include "seb_defines.vh"
module seb_slave #(
    parameter WR_CYCLES = `SEB_WR_CYCLES
) (
    // system
    input wire clk,
    input wire rst,
    // bus pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    // straps and protection
    input wire device_select_pin,
    input wire write_protect,
    // read data supplied by the array side
    input wire [7:0] rd_data,
    // status and received data
    output reg standby,
    output reg busy,
    output reg is_read,
    output reg page_high_addr_bit,
    output reg [16:0] word_addr,
    output reg [7:0] wr_data,
    output reg wr_data_valid,
    output reg rd_next,
    output reg write_start
);
    localparam ST_IDLE = 3'h0;
    localparam ST_RX = 3'h1;
    localparam ST_ACK = 3'h2;
    localparam ST_TX = 3'h3;
    localparam ST_TACK = 3'h4;
    localparam ST_IGN = 3'h5;
    wire [3:0] pins_s;
    wire wp_s;
    wire sel_s;
    reg scl_d;
    reg sda_d;
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shreg;
    reg [1:0] byte_cnt;
    reg wrote;
    reg [31:0] wr_timer;
    wire scl;
    wire sda;
    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire addr_match;

    assign sda_out = 1'b0;

    // straps are pins too; protect acts two clocks late, so change it between transfers
    seb_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .rst(rst),
        .din({scl_in, sda_in, write_protect, device_select_pin}),
        .dout(pins_s)
    );
    assign scl = pins_s[3];
    assign sda = pins_s[2];
    assign wp_s = pins_s[1];
    assign sel_s = pins_s[0];

    always @(posedge clk) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    assign scl_rise = scl & ~scl_d;
    assign scl_fall = ~scl & scl_d;
    // data edges while clock high are framing, not data
    assign start_cond = scl & scl_d & sda_d & ~sda;
    assign stop_cond = scl & scl_d & ~sda_d & sda;
    assign addr_match = (shreg[`SEB_PREFIX_HI:`SEB_PREFIX_LO] == `SEB_PREFIX)
        && (shreg[`SEB_SEL_BIT] == sel_s);

    always @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            byte_cnt <= 2'h0;
            wrote <= 1'b0;
            wr_timer <= 32'h0;
            sda_oe <= 1'b0;
            standby <= 1'b1;
            busy <= 1'b0;
            is_read <= 1'b0;
            page_high_addr_bit <= 1'b0;
            word_addr <= 17'h00000;
            wr_data <= 8'h00;
            wr_data_valid <= 1'b0;
            rd_next <= 1'b0;
            write_start <= 1'b0;
        end else begin
            wr_data_valid <= 1'b0;
            rd_next <= 1'b0;
            write_start <= 1'b0;
            if (busy) begin
                // inputs ignored, no acknowledge while writing
                sda_oe <= 1'b0;
                state <= ST_IDLE;
                if (wr_timer == 32'h0) begin
                    busy <= 1'b0;
                    standby <= 1'b1;
                end else begin
                    wr_timer <= wr_timer - 32'h1;
                end
            end else if (stop_cond) begin
                sda_oe <= 1'b0;
                state <= ST_IDLE;
                if (wrote && !wp_s) begin
                    // a mismatched repeated start may have left standby set
                    standby <= 1'b0;
                    busy <= 1'b1;
                    write_start <= 1'b1;
                    wr_timer <= WR_CYCLES - 1;
                end else begin
                    standby <= 1'b1;
                end
                wrote <= 1'b0;
            end else if (start_cond) begin
                sda_oe <= 1'b0;
                state <= ST_RX;
                standby <= 1'b0;
                bit_cnt <= 4'h0;
                byte_cnt <= 2'h0;
            end else begin
                case (state)
                    ST_RX: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            if (byte_cnt == 2'h0) begin
                                if (addr_match) begin
                                    sda_oe <= 1'b1;
                                    state <= ST_ACK;
                                    page_high_addr_bit <= shreg[`SEB_PAGE_BIT];
                                    word_addr[16] <= shreg[`SEB_PAGE_BIT];
                                    is_read <= shreg[`SEB_RW_BIT];
                                    byte_cnt <= 2'h1;
                                end else begin
                                    state <= ST_IGN;
                                    standby <= 1'b1;
                                end
                            end else begin
                                sda_oe <= 1'b1;
                                state <= ST_ACK;
                                if (byte_cnt == 2'h1) begin
                                    word_addr[15:8] <= shreg;
                                    byte_cnt <= 2'h2;
                                end else if (byte_cnt == 2'h2) begin
                                    word_addr[7:0] <= shreg;
                                    byte_cnt <= 2'h3;
                                end else begin
                                    // protected data is acked but never marked for writing
                                    wr_data <= shreg;
                                    wr_data_valid <= ~wp_s;
                                    wrote <= wrote | ~wp_s;
                                    word_addr[7:0] <= word_addr[7:0] + 8'h01;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (is_read && byte_cnt == 2'h1) begin
                                shreg <= rd_data;
                                sda_oe <= ~rd_data[7];
                                rd_next <= 1'b1;
                                state <= ST_TX;
                            end else begin
                                sda_oe <= 1'b0;
                                state <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        // output changes only on clock fall
                        if (scl_fall) begin
                            if (bit_cnt == 4'h7) begin
                                sda_oe <= 1'b0;
                                bit_cnt <= 4'h0;
                                state <= ST_TACK;
                            end else begin
                                sda_oe <= ~shreg[6];
                                shreg <= {shreg[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    ST_TACK: begin
                        if (scl_rise) begin
                            state <= sda ? ST_IGN : ST_ACK;
                        end
                    end
                    ST_IGN: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### seb_sync.v
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser, first stage read only by the second
module seb_sync #(
    parameter WIDTH = 2
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta;
    always @(posedge clk) begin
        if (rst) begin
            meta <= {WIDTH{1'b1}};
            dout <= {WIDTH{1'b1}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
`default_nettype wire

// ### tb_seb_slave.sv
`timescale 1ns/100ps
`default_nettype none
module tb_seb_slave;
    logic clk = 1'b0, rst = 1'b1, sel = 1'b1, wp = 1'b0, ack;
    logic [7:0] rd_data = 8'hA5, b;
    wire logic scl, sda_drv, sda_out, sda_oe, standby, busy, is_read, page_bit, wdv, rd_next, ws;
    wire logic [16:0] word_addr;
    wire logic [7:0] wr_data;
    // pull-up, either party may pull low
    wire logic sda = (sda_oe ? sda_out : 1'b1) & sda_drv;
    int error_cnt = 0, tests_run = 0, cyc = 0, wv = 0, rv = 0, sv = 0;
    seb_slave #(.WR_CYCLES(200)) DUT (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .device_select_pin(sel), .write_protect(wp), .rd_data(rd_data), .standby(standby),
        .busy(busy), .is_read(is_read), .page_high_addr_bit(page_bit), .word_addr(word_addr), .wr_data(wr_data),
        .wr_data_valid(wdv), .rd_next(rd_next), .write_start(ws));
    seb_ctrl u_ctrl (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wdv === 1'b1) wv <= wv + 1;
        if (rd_next === 1'b1) rv <= rv + 1;
        if (ws === 1'b1) sv <= sv + 1;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic poll(input logic [7:0] a, input logic exp);
        u_ctrl.start();
        u_ctrl.wbyte(a, ack);
        chk(ack, exp);
    endtask
    task automatic wseq();
        poll(8'hA6, 1'b0);
        u_ctrl.wbyte(8'h12, ack);
        chk(ack, 1'b0);
        u_ctrl.wbyte(8'h34, ack);
        u_ctrl.wbyte(8'h5A, ack);
        chk(ack, 1'b0);
        u_ctrl.stop();
        u_ctrl.tk(3);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        u_ctrl.tk(2);
        chk({standby, busy}, 2'b10);
        u_ctrl.recover();
        wseq();
        chk({page_bit, is_read, wr_data, word_addr}, {2'b10, 8'h5A, 17'h11235});
        chk(busy, 1'b1);
        poll(8'hA6, 1'b1);
        u_ctrl.stop();
        for (int i = 0; i < 300 && busy !== 1'b0; i++) u_ctrl.tk(1);
        chk({standby, busy, wv[7:0], sv[7:0]}, {2'b10, 8'h01, 8'h01});
        poll(8'hA2, 1'b1);
        chk(standby, 1'b1);
        u_ctrl.wbyte(8'hA6, ack);
        chk(ack, 1'b1);
        poll(8'hB6, 1'b1);
        sel <= 1'b0;
        poll(8'hA2, 1'b0);
        u_ctrl.stop();
        sel <= 1'b1;
        wp <= 1'b1;
        wseq();
        chk({busy, wv[7:0], sv[7:0]}, {1'b0, 8'h01, 8'h01});
        wp <= 1'b0;
        poll(8'hA7, 1'b0);
        u_ctrl.rbyte(b, 1'b1);
        chk({is_read, b}, 9'h1A5);
        chk({standby, rv[7:0]}, {1'b0, 8'h01});
        u_ctrl.stop();
        u_ctrl.tk(3);
        chk(standby, 1'b1);
        test_done();
    end
endmodule
bind seb_slave seb_props #(.WR_CYCLES(WR_CYCLES)) u_props (.clk(clk), .rst(rst), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_protect(write_protect), .standby(standby), .busy(busy), .wr_data_valid(wr_data_valid),
    .rd_next(rd_next), .write_start(write_start));
`default_nettype wire
